//--- prc_pkg.sv
// ------------------------------------------------------------------
// Constants of the reload and prescale control.
// ------------------------------------------------------------------
`default_nettype none
package prc_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address = 4 x index.
    // ------------------------------------------------------------------
    localparam logic [5:0] CTRL_IDX   = 6'h03;    // Submodule control.
    localparam logic [5:0] LOADC_IDX  = 6'h04;    // Load okay control.
    localparam logic [5:0] STATUS_IDX = 6'h05;    // Active settings status.
    localparam int         ADDR_W     = 8;

    // ------------------------------------------------------------------
    // Submodule control fields.
    // ------------------------------------------------------------------
    localparam int RELOAD_FREQ_LSB = 12;           // Reload frequency code, 4 bits.
    localparam int HALF_EN_BIT     = 11;           // Half-cycle reload enable.
    localparam int FULL_EN_BIT     = 10;           // Full-cycle reload enable.
    localparam int DT_SAMPLE_LSB   = 8;            // Deadtime input sample, 2 bits.
    localparam int RESERVED_BIT    = 7;            // Always reads zero.
    localparam int DIV_SEL_LSB     = 4;            // Clock divide select, 3 bits.
    localparam int IMM_LOAD_BIT    = 2;            // Immediate load mode.

    // ------------------------------------------------------------------
    // Load control and status fields.
    // ------------------------------------------------------------------
    localparam int LOAD_SET_BIT    = 0;            // Write 1 sets the load okay bit.
    localparam int LOAD_CLR_BIT    = 1;            // Write 1 clears the load okay bit.
    localparam int ST_DIV_LSB      = 0;            // Active divide select, 3 bits.
    localparam int ST_FREQ_LSB     = 4;            // Active reload frequency code.
    localparam int ST_OPP_LSB      = 8;            // Opportunity count.
    localparam int ST_LOK_BIT      = 16;           // Load okay bit.

    // ------------------------------------------------------------------
    // Values after reset.
    // ------------------------------------------------------------------
    localparam logic [3:0] RELOAD_FREQ_RST = 4'h0; // Reload on every opportunity.
    localparam logic [2:0] DIV_SEL_RST     = 3'h0; // Divide by one.
    localparam logic [1:0] DT_SAMPLE_RST   = 2'h0;

    // ------------------------------------------------------------------
    // Bus response codes.
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : prc_pkg
`default_nettype wire

//--- prc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the source enable by 2 to the power of div_sel.
module prc_prescaler #(
    parameter int DIV_W = 3                        // Width of the divide select.
) (
    input  wire logic             mclk,            // System clock.
    input  wire logic             reset,           // Asynchronous reset, active high.
    input  wire logic             src_en,          // Source clock enable pulse.
    input  wire logic             restart,         // Restarts the division phase.
    input  wire logic [DIV_W-1:0] div_sel,         // Active divide select.
    output logic                  cnt_en           // Divided enable pulse.
);

    localparam int CNT_W = (1 << DIV_W) - 1;

    logic [CNT_W-1:0] phase_reg;
    logic [CNT_W-1:0] mask;

    // Phase bits that must all be set for a tick.
    always_comb begin
        mask = CNT_W'((1 << div_sel) - 1);
    end

    // Phase counter advances on each source enable.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            phase_reg <= '0;
        end else if (restart) begin
            phase_reg <= '0;
        end else if (src_en) begin
            phase_reg <= phase_reg + CNT_W'(1);
        end
    end

    // One tick per 2**div_sel source enables.
    assign cnt_en = src_en && ((phase_reg & mask) == mask);

endmodule : prc_prescaler
`default_nettype wire

//--- prc_reload_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Codes 1110, 1111 reload every 15th, 16th.
// - Half enable: mid compare match is opportunity.
// - Full enable: end compare match is opportunity.
// - No enable and no immediate mode: no load.
// - Both enables: two opportunities per cycle.
// - Deadtime ends sample auxiliary input, reset clears.
// - Bit 7 reads zero, writes ignored.
// - Divide select scales selected source clock.
// - Divide select reads back buffered value.
// - New divide at cycle start with load okay or in immediate mode.
// - Divide select writes ignored while load okay.
// - Reload every code+1 opportunities, applied per load cycle.
// - Load at opportunity, or immediately in mode.
// - Divide codes 000..111 give 1..128.
module prc_reload_ctrl #(
    parameter int FREQ_W = 4,                      // Width of the reload frequency code.
    parameter int DIV_W  = 3                       // Width of the divide select.
) (
    input  wire logic                        mclk,          // System clock, 10 MHz.
    input  wire logic                        reset,         // Asynchronous reset, active high.
    // AXI4-Lite slave.
    input  wire logic [prc_pkg::ADDR_W-1:0]  s_awaddr,      // Write address.
    input  wire logic [2:0]                  s_awprot,      // Write protection, unused.
    input  wire logic                        s_awvalid,     // Write address valid.
    output logic                             s_awready,     // Write address ready.
    input  wire logic [31:0]                 s_wdata,       // Write data.
    input  wire logic [3:0]                  s_wstrb,       // Write byte strobes.
    input  wire logic                        s_wvalid,      // Write data valid.
    output logic                             s_wready,      // Write data ready.
    output logic [1:0]                       s_bresp,       // Write response.
    output logic                             s_bvalid,      // Write response valid.
    input  wire logic                        s_bready,      // Write response ready.
    input  wire logic [prc_pkg::ADDR_W-1:0]  s_araddr,      // Read address.
    input  wire logic [2:0]                  s_arprot,      // Read protection, unused.
    input  wire logic                        s_arvalid,     // Read address valid.
    output logic                             s_arready,     // Read address ready.
    output logic [31:0]                      s_rdata,       // Read data.
    output logic [1:0]                       s_rresp,       // Read response.
    output logic                             s_rvalid,      // Read data valid.
    input  wire logic                        s_rready,      // Read data ready.
    // Submodule side.
    input  wire logic                        src_clk_en,    // Enable of the clock source select.
    input  wire logic                        mid_match,     // Counter matched mid-cycle compare.
    input  wire logic                        end_match,     // Counter matched cycle-end compare.
    input  wire logic                        dt0_end,       // End of deadtime 0 pulse.
    input  wire logic                        dt1_end,       // End of deadtime 1 pulse.
    input  wire logic                        aux_in_pin,    // Auxiliary channel pin, asynchronous.
    output logic                             counter_en,    // Divided clock enable for the counter.
    output logic                             reload_pulse,  // Move buffered values to active.
    output logic [DIV_W-1:0]                 div_active,    // Divide select in effect.
    output logic                             load_okay_bit  // Load okay flag.
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [FREQ_W-1:0] freq_buf_reg;
    logic [FREQ_W-1:0] freq_act_reg;
    logic [FREQ_W-1:0] opp_cnt_reg;
    logic              half_en_reg;
    logic              full_en_reg;
    logic              imm_load_reg;
    logic [DIV_W-1:0]  div_buf_reg;
    logic [DIV_W-1:0]  div_act_reg;
    logic [1:0]        dt_sample_reg;
    logic              load_okay_reg;
    logic              aux_meta_reg;
    logic              aux_sync_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [1:0]        rresp_reg;
    logic [31:0]       rdata_reg;
    logic              wr_fire;
    logic [5:0]        wr_idx;
    logic [5:0]        rd_idx;
    logic              wr_ctrl;
    logic              wr_loadc;
    logic              load_set;
    logic              load_clr;
    logic              opportunity;
    logic              load_slot;
    logic              div_apply;
    logic [15:0]       ctrl_view;
    logic [31:0]       status_view;

    // ------------------------------------------------------------------
    // Bus handshakes.
    // ------------------------------------------------------------------

    // Address and data are taken together, one write at a time.
    assign wr_fire   = s_awvalid && s_wvalid && !bvalid_reg;
    assign s_awready = wr_fire;
    assign s_wready  = wr_fire;
    assign s_arready = !rvalid_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rresp   = rresp_reg;
    assign s_rdata   = rdata_reg;
    assign wr_idx    = s_awaddr[7:2];
    assign rd_idx    = s_araddr[7:2];
    assign wr_ctrl   = wr_fire && (wr_idx == prc_pkg::CTRL_IDX);
    assign wr_loadc  = wr_fire && (wr_idx == prc_pkg::LOADC_IDX) && s_wstrb[0];
    assign load_set  = wr_loadc && s_wdata[prc_pkg::LOAD_SET_BIT];
    assign load_clr  = wr_loadc && s_wdata[prc_pkg::LOAD_CLR_BIT];

    // Write response, decode error for unmapped words.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= prc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            if ((wr_idx == prc_pkg::CTRL_IDX) || (wr_idx == prc_pkg::LOADC_IDX)
                || (wr_idx == prc_pkg::STATUS_IDX)) begin
                bresp_reg <= prc_pkg::RESP_OKAY;
            end else begin
                bresp_reg <= prc_pkg::RESP_DECERR;
            end
        end else if (s_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data captured on the edge that takes the address, valid the next cycle.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= prc_pkg::RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= prc_pkg::RESP_OKAY;
            if (rd_idx == prc_pkg::CTRL_IDX) begin
                rdata_reg <= {16'h0000, ctrl_view};
            end else if (rd_idx == prc_pkg::LOADC_IDX) begin
                rdata_reg <= {31'h0000_0000, load_okay_reg};
            end else if (rd_idx == prc_pkg::STATUS_IDX) begin
                rdata_reg <= status_view;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= prc_pkg::RESP_DECERR;
            end
        end else if (s_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register views.
    // ------------------------------------------------------------------

    // Control view shows buffered fields; bit 7 and unowned bits read zero.
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[prc_pkg::RELOAD_FREQ_LSB +: FREQ_W] = freq_buf_reg;
        ctrl_view[prc_pkg::HALF_EN_BIT]               = half_en_reg;
        ctrl_view[prc_pkg::FULL_EN_BIT]               = full_en_reg;
        ctrl_view[prc_pkg::DT_SAMPLE_LSB +: 2]        = dt_sample_reg;
        ctrl_view[prc_pkg::RESERVED_BIT]              = 1'b0;
        ctrl_view[prc_pkg::DIV_SEL_LSB +: DIV_W]      = div_buf_reg;
        ctrl_view[prc_pkg::IMM_LOAD_BIT]              = imm_load_reg;
    end

    // Status view shows the settings currently in effect.
    always_comb begin
        status_view = 32'h0000_0000;
        status_view[prc_pkg::ST_DIV_LSB +: DIV_W]   = div_act_reg;
        status_view[prc_pkg::ST_FREQ_LSB +: FREQ_W] = freq_act_reg;
        status_view[prc_pkg::ST_OPP_LSB +: FREQ_W]  = opp_cnt_reg;
        status_view[prc_pkg::ST_LOK_BIT]            = load_okay_reg;
    end

    // ------------------------------------------------------------------
    // Submodule control register.
    // ------------------------------------------------------------------

    // High byte holds reload frequency and the two reload enables.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            freq_buf_reg <= prc_pkg::RELOAD_FREQ_RST;
            half_en_reg  <= 1'b0;
            full_en_reg  <= 1'b0;
        end else if (wr_ctrl && s_wstrb[1]) begin
            freq_buf_reg <= s_wdata[prc_pkg::RELOAD_FREQ_LSB +: FREQ_W];
            half_en_reg  <= s_wdata[prc_pkg::HALF_EN_BIT];
            full_en_reg  <= s_wdata[prc_pkg::FULL_EN_BIT];
        end
    end

    // Low byte holds the load mode and the buffered divide select.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            imm_load_reg <= 1'b0;
            div_buf_reg  <= prc_pkg::DIV_SEL_RST;
        end else if (wr_ctrl && s_wstrb[0]) begin
            imm_load_reg <= s_wdata[prc_pkg::IMM_LOAD_BIT];
            if (!load_okay_reg) begin
                div_buf_reg <= s_wdata[prc_pkg::DIV_SEL_LSB +: DIV_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Load okay flag.
    // ------------------------------------------------------------------

    // Software sets and clears it; a reload clears it, but a set wins.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            load_okay_reg <= 1'b0;
        end else if (load_set) begin
            load_okay_reg <= 1'b1;
        end else if (load_clr || reload_pulse) begin
            load_okay_reg <= 1'b0;
        end
    end

    assign load_okay_bit = load_okay_reg;

    // ------------------------------------------------------------------
    // Reload opportunities and load frequency.
    // ------------------------------------------------------------------

    // Each enabled compare match is one opportunity; both may count.
    assign opportunity = (half_en_reg && mid_match)
                       || (full_en_reg && end_match);

    // Every (code+1)th opportunity closes a load cycle.
    assign load_slot = opportunity && (opp_cnt_reg == freq_act_reg);

    // Opportunity count restarts at each load slot.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            opp_cnt_reg <= '0;
        end else if (load_slot) begin
            opp_cnt_reg <= '0;
        end else if (opportunity) begin
            opp_cnt_reg <= opp_cnt_reg + FREQ_W'(1);
        end
    end

    // New frequency code applies at each load slot.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            freq_act_reg <= prc_pkg::RELOAD_FREQ_RST;
        end else if (load_slot) begin
            freq_act_reg <= freq_buf_reg;
        end
    end

    // Transfer at a load slot or at once in immediate mode, with load okay.
    always_comb begin
        if (imm_load_reg) begin
            reload_pulse = load_okay_reg;
        end else begin
            reload_pulse = load_okay_reg && load_slot;
        end
    end

    // ------------------------------------------------------------------
    // Clock prescaler.
    // ------------------------------------------------------------------

    // Buffered divide select applied at the start of the next cycle.
    assign div_apply = end_match && (load_okay_reg || imm_load_reg);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_act_reg <= prc_pkg::DIV_SEL_RST;
        end else if (div_apply) begin
            div_act_reg <= div_buf_reg;
        end
    end

    assign div_active = div_act_reg;

    // Divider on the selected source clock.
    prc_prescaler #(
        .DIV_W   (DIV_W)
    ) u_prescaler (
        .mclk    (mclk),
        .reset   (reset),
        .src_en  (src_clk_en),
        .restart (div_apply),
        .div_sel (div_act_reg),
        .cnt_en  (counter_en)
    );

    // ------------------------------------------------------------------
    // Deadtime input sampling.
    // ------------------------------------------------------------------

    // Two-stage synchroniser for the auxiliary channel pin.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aux_meta_reg <= 1'b0;
            aux_sync_reg <= 1'b0;
        end else begin
            aux_meta_reg <= aux_in_pin;
            aux_sync_reg <= aux_meta_reg;
        end
    end

    // Each deadtime end captures the synchronised input.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dt_sample_reg <= prc_pkg::DT_SAMPLE_RST;
        end else begin
            if (dt0_end) begin
                dt_sample_reg[0] <= aux_sync_reg;
            end
            if (dt1_end) begin
                dt_sample_reg[1] <= aux_sync_reg;
            end
        end
    end

endmodule : prc_reload_ctrl
`default_nettype wire

//--- prc_reload_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches bus handshakes, reloads and the divided enable.
module prc_reload_ctrl_checker #(
    parameter int DIV_W = 3                 // Width of the divide select.
) (
    input wire logic             mclk,          // Clock.
    input wire logic             reset,         // Reset.
    input wire logic             s_awready,     // Write taken.
    input wire logic             s_bvalid,      // Write answer.
    input wire logic             s_arvalid,     // Read request.
    input wire logic             s_arready,     // Read taken.
    input wire logic             s_rvalid,      // Read answer.
    input wire logic             src_clk_en,    // Source enable.
    input wire logic             end_match,     // Cycle end.
    input wire logic             counter_en,    // Divided enable.
    input wire logic             reload_pulse,  // Transfer.
    input wire logic [DIV_W-1:0] div_active,    // Divide in effect.
    input wire logic             load_okay_bit  // Load okay.
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (reset);

    // A transfer needs load okay and consumes it.
    property p_pulse_lok; reload_pulse |-> load_okay_bit; endproperty
    a_pulse_lok: assert property (p_pulse_lok) else $error("reload without load okay");
    property p_lok_clear; reload_pulse && !s_awready |=> !load_okay_bit && !reload_pulse; endproperty
    a_lok_clear: assert property (p_lok_clear) else $error("load okay kept after reload");

    // Divide moves only at cycle start and gates the source.
    property p_div_when; !$stable(div_active) |-> $past(end_match); endproperty
    a_div_when: assert property (p_div_when) else $error("divide changed off cycle start");
    property p_div_one; div_active == 3'h0 |-> counter_en == src_clk_en; endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one wrong");
    property p_div_gate; counter_en |-> src_clk_en; endproperty
    a_div_gate: assert property (p_div_gate) else $error("counter enable without source");
    property p_div_two; div_active == 3'h1 && counter_en && !end_match |=> !counter_en; endproperty
    a_div_two: assert property (p_div_two) else $error("divide by two too fast");

    // Each bus request is answered next cycle.
    property p_b_after; s_awready |=> s_bvalid; endproperty
    a_b_after: assert property (p_b_after) else $error("write answer late");
    property p_r_after; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_r_after: assert property (p_r_after) else $error("read answer late");

    c_reload: cover property (reload_pulse);
    c_div: cover property (!$stable(div_active));
    c_read: cover property (s_rvalid);
endmodule : prc_reload_ctrl_checker

bind prc_reload_ctrl prc_reload_ctrl_checker #(.DIV_W(DIV_W)) u_chk (.mclk(mclk), .reset(reset),
    .s_awready(s_awready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rvalid(s_rvalid), .src_clk_en(src_clk_en), .end_match(end_match), .counter_en(counter_en),
    .reload_pulse(reload_pulse), .div_active(div_active), .load_okay_bit(load_okay_bit));
`default_nettype wire

//--- test_pwm_submodule_reload_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_pwm_submodule_reload_control;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    localparam logic [7:0] CTL = {prc_pkg::CTRL_IDX, 2'h0};
    localparam logic [7:0] LOK = {prc_pkg::LOADC_IDX, 2'h0};
    logic        mclk = '0, reset = '1, s_awvalid = '0, s_wvalid = '0, s_bready = '0;
    logic        s_arvalid = '0, s_rready = '0, src_clk_en = '0, mid_match = '0, end_match = '0;
    logic        dt0_end = '0, dt1_end = '0, aux_in_pin = '0, s_awready, s_wready, s_bvalid;
    logic        s_arready, s_rvalid, counter_en, reload_pulse, load_okay_bit, pulse_seen, v;
    logic [7:0]  s_awaddr = '0, s_araddr = '0;
    logic [2:0]  s_awprot = '0, s_arprot = '0, div_active;
    logic [3:0]  s_wstrb = '1, fc;
    logic [31:0] s_wdata = '0, s_rdata;
    logic [1:0]  s_bresp, s_rresp, bresp_seen, rresp_seen;
    int          n_errors = 0, tests_run = 0, cycles = 0, seed = 42637, c, e, k, s, r;

    // Device under test; bind adds the checker.
    prc_reload_ctrl dut (.mclk, .reset, .s_awaddr, .s_awprot, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .src_clk_en, .mid_match, .end_match, .dt0_end, .dt1_end,
        .aux_in_pin, .counter_en, .reload_pulse, .div_active, .load_okay_bit);

    // Clock and cycle ceiling.
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Write one word; reload pulse caught at the answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do @(posedge mclk); while (s_awready !== 1'b1);
        s_awvalid <= 1'b0;
        s_wvalid <= 1'b0;
        while (s_bvalid !== 1'b1) @(posedge mclk);
        bresp_seen = s_bresp;
        pulse_seen = reload_pulse;
        s_bready <= 1'b0;
    endtask : wr

    // Read and compare one word.
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge mclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) @(posedge mclk);
        rresp_seen = s_rresp;
        s_rready <= 1'b0;
        chk(name, exp, s_rdata);
    endtask : rd

    // One match pulse: mid if m, else cycle end.
    task automatic opp(input logic m);
        @(posedge mclk);
        mid_match <= m;
        end_match <= !m;
        @(posedge mclk);
        mid_match <= 1'b0;
        end_match <= 1'b0;
        pulse_seen = reload_pulse;
    endtask : opp

    // Set load okay, match until a transfer; e counts.
    task automatic to_reload();
        wr(LOK, 32'h0000_0001);
        e = 0;
        while (!pulse_seen && e < 20) begin
            opp(e[0]);
            e++;
        end
    endtask : to_reload

    function automatic logic [31:0] ctl(input logic [3:0] f, input logic [1:0] hf, input logic [1:0] dt,
                                       input logic [2:0] dv, input logic im);
        return {16'h0000, f, hf, dt, 1'b0, dv, 1'b0, im, 2'h0};
    endfunction : ctl

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd("control", CTL, 32'h0000_0000);
        rd("unmapped", 8'h3c, 32'h0000_0000);
        chk("rresp", {30'h0, prc_pkg::RESP_DECERR}, {30'h0, rresp_seen});
        wr(8'h3c, 32'hffff_ffff);
        chk("bresp", {30'h0, prc_pkg::RESP_DECERR}, {30'h0, bresp_seen});
        wr(CTL, 32'h0000_ffff);
        rd("control", CTL, ctl(4'hf, 2'h3, 2'h0, 3'h7, 1'b1));
        wr(CTL, 32'h0000_0000);
        // Each enable pair against both matches.
        for (c = 0; c < 4; c++) begin
            wr(CTL, ctl(4'h0, 2'(c), 2'h0, 3'h0, 1'b0));
            for (k = 0; k < 2; k++) begin
                wr(LOK, 32'h0000_0001);
                opp(k[0]);
                chk("reload", {31'h0, k[0] ? c[1] : c[0]}, {31'h0, pulse_seen});
            end
        end
        // Reload spacing, edge and random codes.
        for (c = 0; c < 5; c++) begin
            fc = (c == 0) ? 4'h0 : (c < 3) ? 4'(c + 13) : 4'($random(seed));
            wr(CTL, ctl(fc, 2'h3, 2'h0, 3'h0, 1'b0));
            to_reload();
            to_reload();
            chk("spacing", {28'h0, fc} + 32'h1, e);
        end
        // Each divide code: buffered, guarded, applied at cycle start.
        for (c = 0; c < 8; c++) begin
            wr(LOK, 32'h0000_0002);
            wr(CTL, ctl(4'h0, 2'h0, 2'h0, 3'(c), 1'b0));
            wr(LOK, 32'h0000_0001);
            wr(CTL, ctl(4'h0, 2'h0, 2'h0, ~3'(c), 1'b0));
            rd("divide select", CTL, ctl(4'h0, 2'h0, 2'h0, 3'(c), 1'b0));
            chk("divide early", {29'h0, 3'(c == 0 ? 0 : c - 1)}, {29'h0, div_active});
            opp(1'b0);
            @(negedge mclk);
            chk("divide active", {29'h0, 3'(c)}, {29'h0, div_active});
            s = 0;
            e = 0;
            k = 0;
            while (e < 128) begin
                @(posedge mclk);
                e += int'(src_clk_en);
                k += int'(counter_en);
                r = $random(seed);
                v = r[0] && s < 128;
                src_clk_en <= v;
                s += int'(v);
            end
            chk("divided count", 32'h0000_0080 >> c, k);
        end
        wr(LOK, 32'h0000_0002);
        wr(CTL, ctl(4'h0, 2'h0, 2'h0, 3'h7, 1'b1));
        wr(LOK, 32'h0000_0001);
        chk("immediate reload", 32'h0000_0001, {31'h0, pulse_seen});
        rd("load okay", LOK, 32'h0000_0000);
        // Aux input sampled at each deadtime end.
        r = $random(seed);
        aux_in_pin <= r[0];
        repeat (4) @(posedge mclk);
        dt0_end <= 1'b1;
        @(posedge mclk);
        dt0_end <= 1'b0;
        aux_in_pin <= r[1];
        repeat (4) @(posedge mclk);
        dt1_end <= 1'b1;
        @(posedge mclk);
        dt1_end <= 1'b0;
        rd("control", CTL, ctl(4'h0, 2'h0, r[1:0], 3'h7, 1'b1));
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd("control", CTL, 32'h0000_0000);
        summarize();
    end
endmodule : test_pwm_submodule_reload_control
`default_nettype wire
